// *** vga_640x480_timing_gen_tb_top.sv ***
`timescale 1ns/1ns

module vga_640x480_timing_gen_tb_top;
  import vga_pkg::*;

  logic         clk_sys, rst_b, mem_addr_valid, mem_addr_ready;
  logic         mem_data_valid, mem_data_ready, hs_b, vs_b, underrun;
  logic         under_seen;
  logic [2:0]   blue, green;
  logic [1:0]   red;
  vga_addr_type mem_addr, exp_addr;
  vga_pix_type  mem_data;
  vga_pix_type  q[$];
  logic [31:0]  line_clk, hs_low_clk, vs_low_clk, vis_clk, fp_clk;
  logic [31:0]  bp_clk, vs_gap, pix_bad, hs_falls, vs_rises, lines_vis;
  int           n_mismatch, comparisons, cyc, addr_bad;

  // ----------------------------------------------------------------
  // Clock, design and monitor
  // ----------------------------------------------------------------
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  vga_timing_gen dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid),
    .mem_addr_ready(mem_addr_ready), .mem_data(mem_data),
    .mem_data_valid(mem_data_valid), .mem_data_ready(mem_data_ready),
    .hs_b(hs_b), .vs_b(vs_b), .blue(blue), .green(green), .red(red),
    .underrun(underrun));

  vga_mon_model mon (.clk_sys(clk_sys), .rst_b(rst_b), .hs_b(hs_b),
    .vs_b(vs_b), .blue(blue), .green(green), .red(red),
    .line_clk(line_clk), .hs_low_clk(hs_low_clk),
    .vs_low_clk(vs_low_clk), .vis_clk(vis_clk), .fp_clk(fp_clk),
    .bp_clk(bp_clk), .vs_gap(vs_gap), .pix_bad(pix_bad),
    .hs_falls(hs_falls), .vs_rises(vs_rises), .lines_vis(lines_vis));

  // ----------------------------------------------------------------
  // Refresh memory: one word per taken address, answer next cycle
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (mem_data_valid === 1'b1 && mem_data_ready === 1'b1)
      void'(q.pop_front());
    if (rst_b && mem_addr_valid === 1'b1 && mem_addr_ready) begin
      if (mem_addr !== exp_addr) addr_bad++;
      if (exp_addr[9:0] == 10'h27f) exp_addr = {exp_addr[18:10] + 1'b1, 10'h000};
      else exp_addr = exp_addr + 1'b1;
      // Low column bits plus a set top bit: a word is never black
      q.push_back({1'b1, mem_addr[6:0]});
    end
    if (underrun !== 1'b0 && rst_b) under_seen = 1'b1;
    #1;
    mem_data_valid = (q.size() > 0);
    // Released bus alternates between the stale word's inverse and the stale word
    mem_data = (q.size() > 0) ? q[0] : ~mem_data;
  end

  // Hang guard: the run needs about 70k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc >= 80000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Compare and wait helpers
  // ----------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Wait until counter sel (hs falls, vs rises, lines) grows by n
  task automatic wait_evt(input int sel, input int n, input int lim);
    logic [31:0] tgt;
    logic [31:0] now;
    int          k;
    now = (sel == 0) ? hs_falls : (sel == 1) ? vs_rises : lines_vis;
    tgt = now + n;
    k = 0;
    while (now < tgt && k < lim) begin
      @(posedge clk_sys);
      #2;
      k++;
      now = (sel == 0) ? hs_falls : (sel == 1) ? vs_rises : lines_vis;
    end
    chk_val("event wait", tgt, now);
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_bit("hs_b", 1'b1, hs_b);
    chk_bit("vs_b", 1'b1, vs_b);
    chk_val("colour", 32'h0000_0000, {blue, green, red});
    chk_bit("mem_addr_valid", 1'b0, mem_addr_valid);
    chk_val("mem_addr", 32'h0000_0000, {13'h0000, mem_addr});
    chk_bit("mem_data_ready", 1'b1, mem_data_ready);
    chk_bit("underrun", 1'b0, underrun);
  endtask

  // Lines in vertical blanking: period, sync width, nothing lit
  task automatic t_hline();
    wait_evt(0, 2, 4000);
    chk_val("line clocks", 32'h0000_0640, line_clk);
    chk_val("hsync clocks", 32'h0000_00c0, hs_low_clk);
    chk_val("lit in vblank", 32'h0000_0000, lines_vis);
  endtask

  // Frame sync pulse lasts two lines
  task automatic t_vsync();
    wait_evt(1, 1, 20000);
    chk_val("vsync clocks", 32'h0000_0c80, vs_low_clk);
  endtask

  // First visible lines: widths, porches, pixels, fetch order
  task automatic t_visible();
    wait_evt(2, 1, 50000);
    chk_val("visible clocks", 32'h0000_0500, vis_clk);
    chk_val("back porch", 32'h0000_0060, bp_clk);
    // 29 lines plus 144 pixels, two clocks each
    chk_val("vback porch", 32'h0000_b660, vs_gap);
    wait_evt(0, 1, 2000);
    chk_val("front porch", 32'h0000_0020, fp_clk);
    wait_evt(2, 1, 4000);
    chk_val("visible clocks 2", 32'h0000_0500, vis_clk);
    chk_val("bad pixels", 32'h0000_0000, pix_bad);
    chk_val("bad addresses", 32'h0000_0000, addr_bad);
    chk_bit("underrun seen", 1'b0, under_seen);
  endtask

  // Memory stalls mid-line: buffer runs dry, a pulse must follow
  task automatic t_underrun();
    wait_evt(0, 1, 2000);
    repeat (400) @(posedge clk_sys);
    #1;
    mem_addr_ready = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    mem_addr_ready = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_bit("underrun pulse", 1'b1, under_seen);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    mem_addr_ready = 1'b1;
    mem_data_valid = 1'b0;
    mem_data = 8'h00;
    exp_addr = '0;
    under_seen = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    t_reset();
    rst_b = 1'b1;
    t_hline();
    t_vsync();
    t_visible();
    t_underrun();
    give_verdict();
  end
endmodule

// *** vga_defs.svh ***
`ifndef VGA_DEFS_SVH
`define VGA_DEFS_SVH

// ----------------------------------------------------------------
// Clock rates and pixel divider
// ----------------------------------------------------------------
`define VGA_SYS_CLK_HZ   32'h02FA_F080
`define VGA_PIX_CLK_HZ   32'h017D_7840
`define VGA_PIX_DIV      (`VGA_SYS_CLK_HZ / `VGA_PIX_CLK_HZ)

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define VGA_CNT_W        10
`define VGA_ROW_W        9
`define VGA_ADDR_W       19
`define VGA_PIX_W        8

// ----------------------------------------------------------------
// Horizontal line, in pixel clocks
// ----------------------------------------------------------------
`define VGA_H_VIS        10'h280
`define VGA_H_FP         10'h010
`define VGA_H_SYNC       10'h060
`define VGA_H_BP         10'h030
`define VGA_H_TOTAL      (`VGA_H_VIS + `VGA_H_FP + `VGA_H_SYNC + `VGA_H_BP)
`define VGA_H_SYNC_START (`VGA_H_VIS + `VGA_H_FP)
`define VGA_H_SYNC_END   (`VGA_H_SYNC_START + `VGA_H_SYNC)

// ----------------------------------------------------------------
// Vertical frame, in lines
// ----------------------------------------------------------------
`define VGA_V_VIS        10'h1e0
`define VGA_V_FP         10'h00a
`define VGA_V_SYNC       10'h002
`define VGA_V_BP         10'h01d
`define VGA_V_TOTAL      (`VGA_V_VIS + `VGA_V_FP + `VGA_V_SYNC + `VGA_V_BP)
`define VGA_V_SYNC_START (`VGA_V_VIS + `VGA_V_FP)
`define VGA_V_SYNC_END   (`VGA_V_SYNC_START + `VGA_V_SYNC)

// ----------------------------------------------------------------
// Colour fields, reset values, buffer
// ----------------------------------------------------------------
`define VGA_BLUE_MSB     7
`define VGA_BLUE_LSB     5
`define VGA_GREEN_MSB    4
`define VGA_GREEN_LSB    2
`define VGA_RED_MSB      1
`define VGA_RED_LSB      0
`define VGA_PIX_BLANK    8'h00
`define VGA_H_RST        10'h000
`define VGA_V_RST        `VGA_V_VIS
`define VGA_BUF_DEPTH    2'h2

`endif

// *** vga_mon_model.sv ***
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Monitor model: measures sync and colour timing as a display would
// ----------------------------------------------------------------
module vga_mon_model (
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  input  wire logic  hs_b,
  input  wire logic  vs_b,
  input  wire logic  [2:0] blue,
  input  wire logic  [2:0] green,
  input  wire logic  [1:0] red,
  output logic [31:0] line_clk,
  output logic [31:0] hs_low_clk,
  output logic [31:0] vs_low_clk,
  output logic [31:0] vis_clk,
  output logic [31:0] fp_clk,
  output logic [31:0] bp_clk,
  output logic [31:0] vs_gap,
  output logic [31:0] pix_bad,
  output logic [31:0] hs_falls,
  output logic [31:0] vs_rises,
  output logic [31:0] lines_vis
);
  logic [31:0] cyc, hs_fall_at, hs_rise_at, vs_fall_at, vs_rise_at;
  logic [31:0] vis_at, vis_end_at, p;
  logic        hs_p, vs_p, lit_p, lit;
  logic [7:0]  pix;

  assign pix = {blue, green, red};
  assign lit = (pix !== 8'h00);

  // Edge times in clk_sys cycles; behavioural, blocking on purpose
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {cyc, hs_fall_at, hs_rise_at, vs_fall_at, vs_rise_at} = '0;
      {vis_at, vis_end_at, line_clk, hs_low_clk, vs_low_clk} = '0;
      {vis_clk, fp_clk, bp_clk, vs_gap, pix_bad} = '0;
      {hs_falls, vs_rises, lines_vis} = '0;
      hs_p = 1'b1;
      vs_p = 1'b1;
      lit_p = 1'b0;
    end else begin
      cyc = cyc + 1;
      // line length, sync width, low sync
      if (!hs_b && hs_p) begin
        line_clk = cyc - hs_fall_at;
        hs_fall_at = cyc;
        fp_clk = cyc - vis_end_at;
        hs_falls = hs_falls + 1;
      end
      if (hs_b && !hs_p) begin
        hs_low_clk = cyc - hs_fall_at;
        hs_rise_at = cyc;
      end
      // frame sync width and back porch
      if (!vs_b && vs_p) vs_fall_at = cyc;
      if (vs_b && !vs_p) begin
        vs_low_clk = cyc - vs_fall_at;
        vs_rise_at = cyc;
        vs_rises = vs_rises + 1;
      end
      if (lit && !lit_p) begin
        vis_at = cyc;
        bp_clk = cyc - hs_rise_at;
        if (lines_vis == 0) vs_gap = cyc - vs_rise_at;
      end
      if (!lit && lit_p) begin
        vis_end_at = cyc;
        vis_clk = cyc - vis_at;
        lines_vis = lines_vis + 1;
      end
      // colour only in view, right pixel in right period
      if (lit) begin
        p = (cyc - vis_at) >> 1;
        if (pix !== {1'b1, p[6:0]} || !hs_b || !vs_b)
          pix_bad = pix_bad + 1;
      end
      hs_p = hs_b;
      vs_p = vs_b;
      lit_p = lit;
    end
  end
endmodule

// *** vga_pix_buf.sv ***
`timescale 1ns/1ns
`include "vga_defs.svh"

module vga_pix_buf (
  input  wire logic    clk_sys,
  input  wire logic    rst_b,
  input  wire logic    flush,
  vga_strm_if.snk      in_if,
  vga_strm_if.src      out_if,
  output logic [1:0]   fill
);
  import vga_pkg::*;

  vga_buf_state_type s_q;
  vga_buf_state_type s_d;
  logic              push;
  logic              pop;

  // Two-entry ring; ready is a flop so the source sees no comb path
  always_comb begin
    s_d  = s_q;
    push = in_if.valid && s_q.rdy;
    pop  = out_if.ready && (s_q.cnt != 2'h0);
    if (push) begin
      s_d.ent[s_q.wr_ptr] = in_if.data;
      s_d.wr_ptr          = ~s_q.wr_ptr;
    end
    if (pop) begin
      s_d.rd_ptr = ~s_q.rd_ptr;
    end
    case ({push, pop})
      2'h2:    s_d.cnt = s_q.cnt + 2'h1;
      2'h1:    s_d.cnt = s_q.cnt - 2'h1;
      default: s_d.cnt = s_q.cnt;
    endcase
    // Realignment drop, only issued while nothing is in flight
    if (flush) begin
      s_d.cnt    = 2'h0;
      s_d.wr_ptr = 1'b0;
      s_d.rd_ptr = 1'b0;
    end
    s_d.rdy = (s_d.cnt != `VGA_BUF_DEPTH);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_if.ready  = s_q.rdy;
  assign out_if.valid = (s_q.cnt != 2'h0);
  assign out_if.data  = s_q.ent[s_q.rd_ptr];
  assign fill         = s_q.cnt;

  property p_buf_ready_honest;
    @(posedge clk_sys) disable iff (!rst_b)
      (s_q.cnt <= `VGA_BUF_DEPTH) &&
      (in_if.ready == (s_q.cnt != `VGA_BUF_DEPTH));
  endproperty
  a_buf_ready_honest: assert property (p_buf_ready_honest) // RQ8
    else $error("buffer ready does not match its fill");

  property p_buf_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (out_if.valid && !out_if.ready && !flush) |=> out_if.valid;
  endproperty
  a_buf_keep: assert property (p_buf_keep) // RQ8
    else $error("buffer lost a word while stalled");
endmodule

// *** vga_pkg.sv ***
`include "vga_defs.svh"

package vga_pkg;

  // ----------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------
  typedef logic [`VGA_CNT_W-1:0]  vga_cnt_type;
  typedef logic [`VGA_ROW_W-1:0]  vga_row_type;
  typedef logic [`VGA_ADDR_W-1:0] vga_addr_type;
  typedef logic [`VGA_PIX_W-1:0]  vga_pix_type;

  typedef enum logic {FETCH_WAIT, FETCH_RUN} vga_fetch_state_type;

  // ----------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    vga_cnt_type cnt;
  } vga_ctr_state_type;

  typedef struct packed {
    vga_pix_type [1:0] ent;
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        cnt;
    logic              rdy;
  } vga_buf_state_type;

  typedef struct packed {
    logic                div;
    logic                hs_b;
    logic                vs_b;
    vga_pix_type         rgb;
    logic                underrun;
    vga_fetch_state_type fst;
    vga_cnt_type         fcol;
    vga_row_type         frow;
    vga_addr_type        addr;
    logic                addr_vld;
    logic [1:0]          outst;
    logic                flush;
  } vga_top_state_type;

endpackage

// *** vga_scan_ctr.sv ***
`timescale 1ns/1ns

module vga_scan_ctr #(
  parameter vga_pkg::vga_cnt_type LAST    = 10'h000,
  parameter vga_pkg::vga_cnt_type RST_VAL = 10'h000
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  input  wire logic           step,
  output vga_pkg::vga_cnt_type cnt_q,
  output vga_pkg::vga_cnt_type cnt_d
);
  import vga_pkg::*;

  vga_ctr_state_type s_q;
  vga_ctr_state_type s_d;

  // Free-running wrap counter; never stops, only steps on the enable
  always_comb begin
    s_d = s_q;
    if (step) begin
      s_d.cnt = (s_q.cnt == LAST) ? '0 : s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt_q = s_q.cnt;
  assign cnt_d = s_d.cnt;

  property p_cnt_range;
    @(posedge clk_sys) disable iff (!rst_b) s_q.cnt <= LAST;
  endproperty
  a_cnt_range: assert property (p_cnt_range) // RQ7
    else $error("scan counter beyond its last value");

  property p_cnt_hold;
    @(posedge clk_sys) disable iff (!rst_b) !step |=> $stable(s_q.cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) // RQ3
    else $error("scan counter moved without a step");
endmodule

// *** vga_strm_if.sv ***
`timescale 1ns/1ns

// Pixel word stream with valid/ready handshake
interface vga_strm_if;
  import vga_pkg::*;
  logic        valid;
  logic        ready;
  vga_pix_type data;

  modport snk (input valid, input data, output ready);
  modport src (output valid, output data, input ready);
endinterface

// *** vga_timing_gen.sv ***
// Contract
// RQ1: Pixel is 8 bits: three blue, three green, two red on outputs.
// RQ2: Runs on 25 MHz pixel rate, 640x480 frame at about 60 Hz.
// RQ3: Horizontal counter steps per pixel; 800-clock line, 640 visible.
// RQ4: Line blanking: 16 front porch, 96 sync, 48 back porch, no pixels.
// RQ5: Vertical counter steps per sync; 521 lines: 480, 10, 2, 29.
// RQ6: Colour only when both counters visible; blank otherwise.
// RQ7: Counters run freely and together form the refresh memory address; the address comes from separate fetch counters frow and fcol.
// RQ8: Pixel fetched ahead, shown exactly in the period it is scanned.
// RQ9: No fixed sync phase; origins chosen to ease address forming.
// RQ10: Order is display, front porch, sync, back porch; syncs low.
`timescale 1ns/1ns
`include "vga_defs.svh"

module vga_timing_gen (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  output vga_pkg::vga_addr_type mem_addr,
  output logic                  mem_addr_valid,
  input  wire logic             mem_addr_ready,
  input  vga_pkg::vga_pix_type  mem_data,
  input  wire logic             mem_data_valid,
  output logic                  mem_data_ready,
  output logic                  hs_b,
  output logic                  vs_b,
  output logic [2:0]            blue,
  output logic [2:0]            green,
  output logic [1:0]            red,
  output logic                  underrun
);
  import vga_pkg::*;

  // ----------------------------------------------------------------
  // State and local nets
  // ----------------------------------------------------------------
  vga_top_state_type s_q;
  vga_top_state_type s_d;
  vga_cnt_type       h_q;
  vga_cnt_type       h_d;
  vga_cnt_type       v_q;
  vga_cnt_type       v_d;
  logic              pix_en;
  logic              v_step;
  logic              vis_n;
  logic              pop;
  logic              accepted;
  logic              push;
  logic              launch;
  logic [2:0]        in_use;
  logic [1:0]        fill;

  vga_strm_if in_if ();
  vga_strm_if out_if ();

  // ----------------------------------------------------------------
  // Pixel rate enable
  // ----------------------------------------------------------------
  // RQ2 pixel rate divider
  assign pix_en = (s_q.div == 1'(`VGA_PIX_DIV - 1));

  // RQ5 step per sync
  assign v_step = pix_en && (h_q == `VGA_H_SYNC_START - 10'h001);

  // ----------------------------------------------------------------
  // Scan counters
  // ----------------------------------------------------------------
  // Line origin at first visible pixel keeps the address a plain concat
  // RQ9 origin eases addressing
  // RQ3 800-clock line
  vga_scan_ctr #(
    .LAST    (`VGA_H_TOTAL - 10'h001),
    .RST_VAL (`VGA_H_RST)
  ) u_hcnt (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .step    (pix_en),
    .cnt_q   (h_q),
    .cnt_d   (h_d)
  );

  // Starts in vertical blanking so the first frame is prefetched cleanly
  vga_scan_ctr #(
    .LAST    (`VGA_V_TOTAL - 10'h001),
    .RST_VAL (`VGA_V_RST)
  ) u_vcnt (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .step    (v_step),
    .cnt_q   (v_q),
    .cnt_d   (v_d)
  );

  // ----------------------------------------------------------------
  // Pixel buffer
  // ----------------------------------------------------------------
  assign in_if.valid    = mem_data_valid;
  assign in_if.data     = mem_data;
  assign mem_data_ready = in_if.ready;
  assign out_if.ready   = pop;

  vga_pix_buf u_buf (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .flush   (s_q.flush),
    .in_if   (in_if),
    .out_if  (out_if),
    .fill    (fill)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Outputs are built from the next counter values so that sync and
  // colour flops change on the very edge that moves the counters.
  always_comb begin
    s_d          = s_q;
    s_d.underrun = 1'b0;
    s_d.flush    = 1'b0;
    s_d.div      = pix_en ? 1'b0 : s_q.div + 1'b1;

    // RQ6 both counters visible
    vis_n = (h_d < `VGA_H_VIS) && (v_d < `VGA_V_VIS);
    // RQ8 pop in scan period
    pop   = pix_en && vis_n && out_if.valid;

    if (pix_en) begin
      // RQ4 porch and sync widths
      // RQ10 active-low sync decode
      s_d.hs_b = !((h_d >= `VGA_H_SYNC_START) && (h_d < `VGA_H_SYNC_END));
      s_d.vs_b = !((v_d >= `VGA_V_SYNC_START) && (v_d < `VGA_V_SYNC_END));
      // RQ6 blank outside display
      if (!vis_n) begin
        s_d.rgb = `VGA_PIX_BLANK;
      end else if (out_if.valid) begin
        s_d.rgb = out_if.data;
      end else begin
        // Late memory: show black rather than a stale pixel
        s_d.rgb      = `VGA_PIX_BLANK;
        s_d.underrun = 1'b1;
      end
    end

    // Fetch bookkeeping: requests in flight plus words held
    accepted = s_q.addr_vld && mem_addr_ready;
    push     = in_if.valid && in_if.ready;
    if (accepted) begin
      s_d.addr_vld = 1'b0;
    end
    case ({accepted, push})
      2'h2:    s_d.outst = s_q.outst + 2'h1;
      2'h1:    s_d.outst = s_q.outst - 2'h1;
      default: s_d.outst = s_q.outst;
    endcase
    // Conservative credit: never ask for more than the buffer can hold
    in_use = {1'b0, fill} + {1'b0, s_q.outst} + {2'h0, s_q.addr_vld};
    launch = (s_q.fst == FETCH_RUN) && (!s_q.addr_vld || accepted) &&
             (in_use < {1'b0, `VGA_BUF_DEPTH});

    case (s_q.fst)
      FETCH_RUN: begin
        if (launch) begin
          // RQ7 address from position
          s_d.addr     = {s_q.frow, s_q.fcol};
          s_d.addr_vld = 1'b1;
          if (s_q.fcol == `VGA_H_VIS - 10'h001) begin
            s_d.fcol = '0;
            s_d.frow = s_q.frow + 9'h001;
            if ({1'b0, s_q.frow} == `VGA_V_VIS - 10'h001) begin
              s_d.fst = FETCH_WAIT;
            end
          end else begin
            s_d.fcol = s_q.fcol + 10'h001;
          end
        end
      end
      FETCH_WAIT: begin
        // Realign in vertical blanking once the frame's fetch is done; an underrun of
        // up to two pixels spoils only the rest of its own frame, a longer one the next too
        if ((v_q >= `VGA_V_VIS) && (s_q.outst == 2'h0) && !s_q.addr_vld) begin
          s_d.flush = 1'b1;
          s_d.fcol  = '0;
          s_d.frow  = '0;
          s_d.fst   = FETCH_RUN;
        end
      end
      default: begin
        s_d.fst = FETCH_WAIT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q      <= '0;
      s_q.hs_b <= 1'b1;
      s_q.vs_b <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  // RQ1 colour field split
  assign blue           = s_q.rgb[`VGA_BLUE_MSB:`VGA_BLUE_LSB];
  assign green          = s_q.rgb[`VGA_GREEN_MSB:`VGA_GREEN_LSB];
  assign red            = s_q.rgb[`VGA_RED_MSB:`VGA_RED_LSB];
  assign hs_b           = s_q.hs_b;
  assign vs_b           = s_q.vs_b;
  assign mem_addr       = s_q.addr;
  assign mem_addr_valid = s_q.addr_vld;
  assign underrun       = s_q.underrun;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_pix_gap;
    !pix_en ##1 pix_en;
  endsequence

  property p_pix_rate;
    pix_en |=> s_pix_gap;
  endproperty
  a_pix_rate: assert property (p_pix_rate) // RQ2
    else $error("pixel enable not every second clock");

  property p_h_step;
    (pix_en && h_q != `VGA_H_TOTAL - 10'h001) |=> h_q == $past(h_q) + 10'h001;
  endproperty
  a_h_step: assert property (p_h_step) // RQ3
    else $error("horizontal counter did not advance");

  property p_h_wrap;
    (pix_en && h_q == `VGA_H_TOTAL - 10'h001) |=> h_q == '0;
  endproperty
  a_h_wrap: assert property (p_h_wrap) // RQ3
    else $error("horizontal counter did not wrap at line end");

  property p_hs_window;
    hs_b == !((h_q >= `VGA_H_SYNC_START) && (h_q < `VGA_H_SYNC_END));
  endproperty
  a_hs_window: assert property (p_hs_window) // RQ4
    else $error("horizontal sync outside its window");

  property p_v_step;
    $fell(hs_b) |-> v_q == (($past(v_q) == `VGA_V_TOTAL - 10'h001) ?
                            10'h000 : $past(v_q) + 10'h001);
  endproperty
  a_v_step: assert property (p_v_step) // RQ5
    else $error("vertical counter not stepped by sync");

  property p_vs_window;
    vs_b == !((v_q >= `VGA_V_SYNC_START) && (v_q < `VGA_V_SYNC_END));
  endproperty
  a_vs_window: assert property (p_vs_window) // RQ10
    else $error("vertical sync outside its window");

  property p_blank;
    ((h_q >= `VGA_H_VIS) || (v_q >= `VGA_V_VIS)) |-> s_q.rgb == `VGA_PIX_BLANK;
  endproperty
  a_blank: assert property (p_blank) // RQ6
    else $error("colour driven during blanking");

  sequence s_shown;
    (h_q < `VGA_H_VIS) && (v_q < `VGA_V_VIS);
  endsequence

  property p_pop_align;
    pop |=> s_shown and (s_q.rgb == $past(out_if.data));
  endproperty
  a_pop_align: assert property (p_pop_align) // RQ8
    else $error("fetched pixel not shown in its scan period");

  property p_addr_range;
    s_q.addr_vld |->
      (s_q.addr[`VGA_CNT_W-1:0] < `VGA_H_VIS) &&
      ({1'b0, s_q.addr[`VGA_ADDR_W-1:`VGA_CNT_W]} < `VGA_V_VIS);
  endproperty
  a_addr_range: assert property (p_addr_range) // RQ7
    else $error("refresh address outside visible area");

  property p_addr_form;
    launch |=> s_q.addr == {$past(s_q.frow), $past(s_q.fcol)} ##1 1'b1;
  endproperty
  a_addr_form: assert property (p_addr_form) // RQ9
    else $error("refresh address not row and column joined");

  property p_under_black;
    underrun |-> s_q.rgb == `VGA_PIX_BLANK;
  endproperty
  a_under_black: assert property (p_under_black) // RQ8
    else $error("underrun pixel not shown black");

  property p_addr_hold;
    (s_q.addr_vld && !mem_addr_ready) |=> s_q.addr_vld && $stable(s_q.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) // RQ7
    else $error("refresh request dropped before taken");
endmodule
